// ### core/dhlc_pkg.sv
// package: register offsets, field positions and constants of the dma link
package dhlc_pkg;
  // register byte addresses on apb
  localparam logic [7:0] DHLC_OFS_CTRL   = 8'h00;
  localparam logic [7:0] DHLC_OFS_UPPER  = 8'h04;
  localparam logic [7:0] DHLC_OFS_STATUS = 8'h08;
  localparam logic [7:0] DHLC_OFS_COUNT  = 8'h0C;
  localparam logic [7:0] DHLC_OFS_OUTBUF = 8'h10;
  localparam logic [7:0] DHLC_OFS_INBUF  = 8'h14;
  localparam logic [7:0] DHLC_OFS_IRQ    = 8'h18;
  // control register field positions
  localparam int DHLC_CTL_STA   = 0;
  localparam int DHLC_CTL_C0    = 3;
  localparam int DHLC_CTL_C1    = 4;
  localparam int DHLC_CTL_SGL   = 5;
  localparam int DHLC_CTL_ABORT_NOTIFY  = 6;
  localparam int DHLC_CTL_SUPV  = 7;
  // status byte field positions
  localparam int DHLC_ST_FN     = 0;
  localparam int DHLC_ST_IPC    = 3;
  localparam int DHLC_ST_RDYN   = 4;
  localparam int DHLC_ST_DONE   = 5;
  localparam int DHLC_ST_INIT   = 6;
  // values after reset
  localparam logic [7:0]  DHLC_CTRL_RST  = 8'h20;
  localparam logic [6:0]  DHLC_UPPER_RST = 7'h00;
  localparam logic [15:0] DHLC_COUNT_RST = 16'h0000;
  localparam logic [15:0] DHLC_DATA_RST  = 16'h0000;
  localparam int          DHLC_CNT_W     = 16;
  typedef enum logic [2:0] {
    DHLC_IDLE = 3'b000,
    DHLC_WAIT = 3'b001,
    DHLC_REQ  = 3'b010,
    DHLC_BUSY = 3'b011,
    DHLC_NEXT = 3'b100
  } dhlc_state_t;
endpackage

// ### core/dhlc_top.sv
// dma host link control: apb registers, link handshake and status byte
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module dhlc_top #(
  parameter bit BUSY_ACTIVE_HIGH = 1'b1
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [15:0] link_data_out,
  input  wire logic [15:0] link_data_in,
  output logic      [2:0]  user_status_out,
  input  wire logic [2:0]  host_function_inputs,
  input  wire logic        host_init_in,
  input  wire logic        interprocessor_flag_in,
  input  wire logic        host_ready_n,
  input  wire logic        host_busy,
  input  wire logic        host_attention,
  output logic             cycle_request,
  output logic             cycle_type_low,
  output logic             cycle_type_high,
  output logic             single_cycle,
  output logic             abort_notify,
  output logic             low_address_bit,
  output logic             word_counter_advance,
  output logic             bus_address_advance,
  output logic      [6:0]  upper_address_bits,
  output logic             supervisor_space,
  output logic             dma_irq
);
  // package items under local names; nothing is imported
  typedef dhlc_pkg::dhlc_state_t dhlc_state_t;
  localparam dhlc_state_t DHLC_IDLE = dhlc_pkg::DHLC_IDLE;
  localparam dhlc_state_t DHLC_WAIT = dhlc_pkg::DHLC_WAIT;
  localparam dhlc_state_t DHLC_REQ  = dhlc_pkg::DHLC_REQ;
  localparam dhlc_state_t DHLC_BUSY = dhlc_pkg::DHLC_BUSY;
  localparam dhlc_state_t DHLC_NEXT = dhlc_pkg::DHLC_NEXT;

  // register byte addresses
  localparam logic [7:0]  DHLC_OFS_CTRL   = dhlc_pkg::DHLC_OFS_CTRL;
  localparam logic [7:0]  DHLC_OFS_UPPER  = dhlc_pkg::DHLC_OFS_UPPER;
  localparam logic [7:0]  DHLC_OFS_STATUS = dhlc_pkg::DHLC_OFS_STATUS;
  localparam logic [7:0]  DHLC_OFS_COUNT  = dhlc_pkg::DHLC_OFS_COUNT;
  localparam logic [7:0]  DHLC_OFS_OUTBUF = dhlc_pkg::DHLC_OFS_OUTBUF;
  localparam logic [7:0]  DHLC_OFS_INBUF  = dhlc_pkg::DHLC_OFS_INBUF;
  localparam logic [7:0]  DHLC_OFS_IRQ    = dhlc_pkg::DHLC_OFS_IRQ;

  // control and status field positions
  localparam int          DHLC_CTL_STA    = dhlc_pkg::DHLC_CTL_STA;
  localparam int          DHLC_CTL_C0     = dhlc_pkg::DHLC_CTL_C0;
  localparam int          DHLC_CTL_C1     = dhlc_pkg::DHLC_CTL_C1;
  localparam int          DHLC_CTL_SGL    = dhlc_pkg::DHLC_CTL_SGL;
  localparam int          DHLC_CTL_ABORT_NOTIFY   = dhlc_pkg::DHLC_CTL_ABORT_NOTIFY;
  localparam int          DHLC_CTL_SUPV   = dhlc_pkg::DHLC_CTL_SUPV;
  localparam int          DHLC_ST_FN      = dhlc_pkg::DHLC_ST_FN;
  localparam int          DHLC_ST_IPC     = dhlc_pkg::DHLC_ST_IPC;
  localparam int          DHLC_ST_RDYN    = dhlc_pkg::DHLC_ST_RDYN;
  localparam int          DHLC_ST_DONE    = dhlc_pkg::DHLC_ST_DONE;
  localparam int          DHLC_ST_INIT    = dhlc_pkg::DHLC_ST_INIT;

  // values after reset
  localparam logic [7:0]  DHLC_CTRL_RST   = dhlc_pkg::DHLC_CTRL_RST;
  localparam logic [6:0]  DHLC_UPPER_RST  = dhlc_pkg::DHLC_UPPER_RST;
  localparam logic [15:0] DHLC_COUNT_RST  = dhlc_pkg::DHLC_COUNT_RST;
  localparam logic [15:0] DHLC_DATA_RST   = dhlc_pkg::DHLC_DATA_RST;

  typedef struct packed {
    // pin synchronisers, two stages each
    logic [1:0]            fn_s1;
    logic [1:0]            fn_s2;
    logic [1:0]            fn_s3;
    logic [1:0]            init_s;
    logic [1:0]            ipc_s;
    logic [1:0]            rdy_s;
    logic [1:0]            busy_s;
    logic [1:0]            abort_notify_s;
    logic [15:0]           din1;
    logic [15:0]           din_s;
    // software-visible registers
    logic [7:0]            ctrl;
    logic [6:0]            upper;
    logic [15:0]           count;
    logic [15:0]           outbuf;
    logic [15:0]           inbuf;
    // interrupt and sequencer state, and registered read data
    logic                  irq_mask;
    logic                  fn2_flag;
    logic                  done;
    logic                  req;
    logic                  advance;
    dhlc_state_t           state;
    logic [31:0]           rdata;
  } dhlc_regs_t;

  dhlc_regs_t cur_ff;
  dhlc_regs_t nxt_cur;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  logic       acc;
  logic       wr;
  logic       busy_act;
  logic [7:0] status_byte;

  assign acc      = psel && penable;
  assign wr       = acc && pwrite;
  assign busy_act = (cur_ff.busy_s[1] == BUSY_ACTIVE_HIGH);

  // one decode per register, shared by the write and read paths
  logic       sel_ctrl;
  logic       sel_upper;
  logic       sel_status;
  logic       sel_count;
  logic       sel_outbuf;
  logic       sel_inbuf;
  logic       sel_irq;

  assign sel_ctrl   = hit(paddr, DHLC_OFS_CTRL);
  assign sel_upper  = hit(paddr, DHLC_OFS_UPPER);
  assign sel_status = hit(paddr, DHLC_OFS_STATUS);
  assign sel_count  = hit(paddr, DHLC_OFS_COUNT);
  assign sel_outbuf = hit(paddr, DHLC_OFS_OUTBUF);
  assign sel_inbuf  = hit(paddr, DHLC_OFS_INBUF);
  assign sel_irq    = hit(paddr, DHLC_OFS_IRQ);

  always_comb begin
    status_byte = 8'h00;
    status_byte[DHLC_ST_FN +: 3] = {cur_ff.fn_s3[1], cur_ff.fn_s2[1],
                                    cur_ff.fn_s1[1]};
    status_byte[DHLC_ST_IPC]  = cur_ff.fn_s2[1];
    status_byte[DHLC_ST_RDYN] = cur_ff.rdy_s[1];
    status_byte[DHLC_ST_DONE] = cur_ff.done;
    status_byte[DHLC_ST_INIT] = cur_ff.init_s[1];
    status_byte[7]            = cur_ff.ipc_s[1];
  end

  always_comb begin
    nxt_cur = cur_ff;
    // two-stage synchronisers on every host pin
    nxt_cur.fn_s1  = {cur_ff.fn_s1[0], host_function_inputs[0]};
    nxt_cur.fn_s2  = {cur_ff.fn_s2[0], host_function_inputs[1]};
    nxt_cur.fn_s3  = {cur_ff.fn_s3[0], host_function_inputs[2]};
    nxt_cur.init_s = {cur_ff.init_s[0], host_init_in};
    nxt_cur.ipc_s  = {cur_ff.ipc_s[0], interprocessor_flag_in};
    nxt_cur.rdy_s  = {cur_ff.rdy_s[0], host_ready_n};
    nxt_cur.busy_s = {cur_ff.busy_s[0], host_busy};
    nxt_cur.abort_notify_s = {cur_ff.abort_notify_s[0], host_attention};
    nxt_cur.din1   = link_data_in;
    nxt_cur.din_s  = cur_ff.din1;

    // register writes
    if (wr && sel_ctrl && pstrb[0]) begin
      nxt_cur.ctrl = pwdata[7:0];
    end
    // the count runs up towards zero; a start value of zero wraps
    // round and moves the full counter range of words
    if (wr && sel_count && (pstrb[1:0] == 2'b11)) begin
      nxt_cur.count = pwdata[15:0];
    end
    // the output latch belongs to the sequencer while a transfer runs
    if (wr && sel_outbuf &&
        (cur_ff.state == DHLC_IDLE)) begin
      nxt_cur.outbuf = pwdata[15:0];
    end
    if (wr && sel_irq) begin
      nxt_cur.irq_mask = pwdata[0];
      if (pwdata[1]) begin
        nxt_cur.fn2_flag = 1'b0;
      end
    end
    // set wins over the software clear
    if (cur_ff.fn_s2[1]) begin
      nxt_cur.fn2_flag = 1'b1;
    end

    // transfer sequencer
    // both counter enables pulse together, one cycle per word
    nxt_cur.advance = 1'b0;
    unique case (cur_ff.state)
      DHLC_IDLE: begin
        nxt_cur.req = 1'b0;
      end
      // a request waits for busy seen idle through the synchroniser, so
      // a late busy from an aborted cycle holds off the next request
      DHLC_WAIT: begin
        if (!cur_ff.rdy_s[1] && !busy_act) begin
          nxt_cur.state = DHLC_REQ;
        end
      end
      DHLC_REQ: begin
        nxt_cur.req = 1'b1;
        if (busy_act) begin
          nxt_cur.req   = 1'b0;
          nxt_cur.state = DHLC_BUSY;
        end
      end
      DHLC_BUSY: begin
        if (!busy_act) begin
          if (cur_ff.ctrl[DHLC_CTL_C1] == 1'b0) begin
            nxt_cur.inbuf = cur_ff.din_s;
          end
          nxt_cur.advance = 1'b1;
          nxt_cur.count = cur_ff.count + 16'h0001;
          nxt_cur.state = DHLC_NEXT;
        end
      end
      DHLC_NEXT: begin
        if (cur_ff.count == DHLC_COUNT_RST) begin
          nxt_cur.done  = 1'b1;
          nxt_cur.state = DHLC_IDLE;
        end else begin
          nxt_cur.state = DHLC_WAIT;
        end
      end
      default: begin
        nxt_cur.state = DHLC_IDLE;
      end
    endcase

    // a write to the upper address arms a new transfer
    if (wr && sel_upper && pstrb[0]) begin
      nxt_cur.upper = pwdata[6:0];
      nxt_cur.done  = 1'b0;
      nxt_cur.req   = 1'b0;
      nxt_cur.state = DHLC_WAIT;
    end
    // host attention, function input two or own abort ends the transfer at once
    if (cur_ff.abort_notify_s[1] || cur_ff.fn_s2[1] ||
        (cur_ff.ctrl[DHLC_CTL_ABORT_NOTIFY] && cur_ff.state != DHLC_IDLE)) begin
      nxt_cur.state = DHLC_IDLE;
      nxt_cur.req   = 1'b0;
      nxt_cur.done  = 1'b1;
    end
    if (cur_ff.abort_notify_s[1]) begin
      nxt_cur.fn2_flag = 1'b1;
    end

    // read data, registered for the access phase
    nxt_cur.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (sel_ctrl) begin
        nxt_cur.rdata = {24'h000000, cur_ff.ctrl};
      end else if (sel_status) begin
        nxt_cur.rdata = {24'h000000, status_byte};
      end else if (sel_inbuf) begin
        nxt_cur.rdata = {16'h0000, cur_ff.inbuf};
      end else if (sel_outbuf) begin
        nxt_cur.rdata = {16'h0000, cur_ff.outbuf};
      end else if (sel_irq) begin
        nxt_cur.rdata = {30'h00000000, cur_ff.fn2_flag, cur_ff.irq_mask};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff.fn_s1    <= 2'b00;
      cur_ff.fn_s2    <= 2'b00;
      cur_ff.fn_s3    <= 2'b00;
      cur_ff.init_s   <= 2'b00;
      cur_ff.ipc_s    <= 2'b00;
      cur_ff.busy_s   <= 2'b00;
      cur_ff.abort_notify_s   <= 2'b00;
      cur_ff.din1     <= 16'h0000;
      cur_ff.din_s    <= 16'h0000;
      cur_ff.fn2_flag <= 1'b0;
      cur_ff.req      <= 1'b0;
      cur_ff.advance  <= 1'b0;
      cur_ff.rdata    <= 32'h0000_0000;
      // done set at reset: the engine is ready to be programmed
      cur_ff.ctrl     <= DHLC_CTRL_RST;
      cur_ff.upper    <= DHLC_UPPER_RST;
      cur_ff.count    <= DHLC_COUNT_RST;
      cur_ff.outbuf   <= DHLC_DATA_RST;
      cur_ff.inbuf    <= DHLC_DATA_RST;
      cur_ff.irq_mask <= 1'b1;
      cur_ff.rdy_s    <= 2'b11;
      cur_ff.done     <= 1'b1;
      cur_ff.state    <= DHLC_IDLE;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // one wait-free access; upper address reads as zero (write only)
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = cur_ff.rdata;

  assign link_data_out        = cur_ff.outbuf;
  assign user_status_out      = cur_ff.ctrl[DHLC_CTL_STA +: 3];
  assign cycle_type_low       = cur_ff.ctrl[DHLC_CTL_C0];
  assign cycle_type_high      = cur_ff.ctrl[DHLC_CTL_C1];
  assign single_cycle         = cur_ff.ctrl[DHLC_CTL_SGL];
  assign abort_notify         = cur_ff.ctrl[DHLC_CTL_ABORT_NOTIFY];
  assign supervisor_space     = cur_ff.ctrl[DHLC_CTL_SUPV];
  assign upper_address_bits   = cur_ff.upper;
  assign cycle_request        = cur_ff.req;
  assign low_address_bit      = 1'b0;
  assign word_counter_advance = cur_ff.advance;
  assign bus_address_advance  = cur_ff.advance;
  // mask bit low lets the request through
  assign dma_irq = cur_ff.fn2_flag && !cur_ff.irq_mask;
endmodule // dhlc_top

// ### test/dhlc_host_model.sv
// behavioural host adapter answering link cycle requests
`timescale 1ns/1ps
module dhlc_host_model #(
  parameter bit BUSY_HI = 1'b1
) (
  input  wire logic        pclk,
  input  wire logic        cycle_request,
  input  wire logic        slow,
  input  wire logic        not_rdy,
  input  wire logic [15:0] word,
  output logic             host_ready_n,
  output logic             host_busy,
  output logic      [15:0] link_data_in
);
  logic last_req = 1'b0;
  assign host_ready_n = not_rdy; // low while able to take a transfer
  initial begin
    host_busy = !BUSY_HI;
    link_data_in = 16'hFFFF;
    forever begin
      @(posedge pclk);
      if (cycle_request === 1'b1 && !last_req) begin
        repeat (slow ? 8 : 1) @(posedge pclk);
        link_data_in <= word;
        host_busy <= BUSY_HI; // active for the whole cycle
        repeat (slow ? 12 : 4) @(posedge pclk);
        host_busy <= !BUSY_HI; // return to idle ends the cycle
      end
      last_req = cycle_request;
    end
  end
endmodule // dhlc_host_model

// ### test/dhlc_sva.sv
// port checker for the dma host link control block
`timescale 1ns/1ps
module dhlc_sva #(
  parameter bit BUSY_ACTIVE_HIGH = 1'b1
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic [2:0]  user_status_out,
  input wire logic        cycle_request,
  input wire logic        cycle_type_low,
  input wire logic        cycle_type_high,
  input wire logic        single_cycle,
  input wire logic        abort_notify,
  input wire logic        supervisor_space,
  input wire logic        low_address_bit,
  input wire logic        word_counter_advance,
  input wire logic        bus_address_advance,
  input wire logic [6:0]  upper_address_bits,
  input wire logic        host_busy
);
  logic wr_ok;
  logic wr_ctl;
  assign wr_ok  = psel && penable && pwrite && pstrb[0];
  assign wr_ctl = wr_ok && paddr == dhlc_pkg::DHLC_OFS_CTRL;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_status_lines: assert property (
    wr_ctl |=> user_status_out == $past(pwdata[2:0]))
    else $error("status lines differ from control write");
  a_cycle_type: assert property (
    wr_ctl |=> {cycle_type_high, cycle_type_low} == $past(pwdata[4:3]))
    else $error("cycle type differs from control write");
  a_mode_bits: assert property (
    wr_ctl |=> single_cycle == $past(pwdata[5])
      && supervisor_space == $past(pwdata[7]))
    else $error("mode bits differ from control write");
  a_abort_bit: assert property (
    wr_ctl |=> abort_notify == $past(pwdata[6]))
    else $error("abort line differs from control write");
  a_upper_addr: assert property (
    wr_ok && paddr == dhlc_pkg::DHLC_OFS_UPPER
      |=> upper_address_bits == $past(pwdata[6:0]))
    else $error("upper address not loaded");
  a_ipc_mirror: assert property (
    psel && penable && !pwrite && paddr == dhlc_pkg::DHLC_OFS_STATUS
      |-> prdata[3] == prdata[1])
    else $error("ipc status differs from function two");
  a_low_addr: assert property (!low_address_bit)
    else $error("low address line left word mode");
  a_req_idle_busy: assert property (
    $rose(cycle_request) |-> host_busy != BUSY_ACTIVE_HIGH)
    else $error("request raised while busy active");
  a_req_release: assert property (
    cycle_request && host_busy == BUSY_ACTIVE_HIGH |-> ##[1:5] !cycle_request)
    else $error("request not dropped after busy");
  a_advance_pair: assert property (
    $rose(word_counter_advance) |-> bus_address_advance
      ##1 !word_counter_advance)
    else $error("advance enables not paired pulses");
endmodule // dhlc_sva
bind dhlc_top dhlc_sva #(.BUSY_ACTIVE_HIGH(BUSY_ACTIVE_HIGH)) i_dhlc_sva (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .user_status_out, .cycle_request, .cycle_type_low,
  .cycle_type_high, .single_cycle, .abort_notify, .supervisor_space,
  .low_address_bit, .word_counter_advance, .bus_address_advance,
  .upper_address_bits, .host_busy);

// ### test/dhlc_top_tb.sv
// self-checking bench for the dma host link control block
`timescale 1ns/1ps
module dhlc_top_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, c;
  logic [31:0] pwdata = 32'h0, prdata, q, r;
  logic [3:0] pstrb = 4'hF;
  logic [2:0] user_status_out, host_function_inputs = 3'h0;
  logic [15:0] link_data_out, link_data_in, word = 16'h0;
  logic pready, pslverr, slow = 0, not_rdy = 0, host_attention = 0;
  logic host_init_in = 0, interprocessor_flag_in = 0, creq_q = 0;
  logic host_ready_n, host_busy, cycle_request, cycle_type_low, dma_irq;
  logic cycle_type_high, single_cycle, abort_notify, low_address_bit;
  logic word_counter_advance, bus_address_advance, supervisor_space;
  logic [6:0] upper_address_bits;
  int bad_count = 0, check_count = 0, adv_n = 0, req_n = 0;
  always #5 pclk = ~pclk;
  dhlc_top i_dhlc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .link_data_out,
    .link_data_in, .user_status_out, .host_function_inputs, .host_init_in,
    .interprocessor_flag_in, .host_ready_n, .host_busy, .host_attention,
    .cycle_request, .cycle_type_low, .cycle_type_high, .single_cycle,
    .abort_notify, .low_address_bit, .word_counter_advance,
    .bus_address_advance, .upper_address_bits, .supervisor_space, .dma_irq);
  dhlc_host_model i_dhlc_host_model (.pclk, .cycle_request, .slow,
    .not_rdy, .word, .host_ready_n, .host_busy, .link_data_in);
  always @(posedge pclk) begin
    creq_q <= cycle_request;
    if (word_counter_advance === 1'b1) adv_n++;
    if (cycle_request === 1'b1 && creq_q === 1'b0) req_n++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input int d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  // status byte as the inputs stand, after two sync stages settle
  function automatic logic [31:0] st(input logic dn);
    return {24'h0, interprocessor_flag_in, host_init_in, dn, host_ready_n,
            host_function_inputs[1], host_function_inputs};
  endfunction
  task automatic xfer(input int n, input logic [7:0] ctl);
    adv_n = 0; req_n = 0;
    apb(1, dhlc_pkg::DHLC_OFS_COUNT, -n);
    apb(1, dhlc_pkg::DHLC_OFS_CTRL, ctl);
    apb(1, dhlc_pkg::DHLC_OFS_UPPER, 7'h5A);
  endtask
  task automatic wait_done;
    repeat (300) begin
      apb(0, dhlc_pkg::DHLC_OFS_STATUS, 0);
      if (q[5] === 1'b1) break;
    end
    chk(q[5], 1);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'hFD60));
    repeat (4) @(posedge pclk);
    presetn <= 1;
    apb(0, dhlc_pkg::DHLC_OFS_CTRL, 0);
    chk(q, dhlc_pkg::DHLC_CTRL_RST);
    apb(0, 8'h1C, 0);
    chk(q, 0);
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      c = {r[7], 1'b0, r[5], i[1:0], r[2:0]};
      apb(1, dhlc_pkg::DHLC_OFS_CTRL, c);
      apb(0, dhlc_pkg::DHLC_OFS_CTRL, 0);
      chk(q, c);
      chk({single_cycle, cycle_type_high, cycle_type_low, user_status_out},
          c[5:0]);
      chk(supervisor_space, c[7]);
    end
    $display("control codes done");
    r = $urandom;
    {host_function_inputs, host_init_in, interprocessor_flag_in} <= r[4:0] & 5'h17;
    not_rdy <= 1;
    repeat (4) @(posedge pclk);
    apb(1, dhlc_pkg::DHLC_OFS_STATUS, 32'hFF);
    apb(0, dhlc_pkg::DHLC_OFS_STATUS, 0);
    chk(q, st(1));
    $display("status byte done");
    word <= 16'($urandom);
    xfer(2, 8'h00);
    chk(upper_address_bits, 7'h5A);
    repeat (20) @(posedge pclk);
    chk(req_n, 0);
    not_rdy <= 0;
    wait_done();
    chk(adv_n, 2);
    chk(req_n, 2);
    apb(0, dhlc_pkg::DHLC_OFS_INBUF, 0);
    chk(q, {16'h0, word});
    apb(1, dhlc_pkg::DHLC_OFS_OUTBUF, 32'h0000C35A);
    chk(link_data_out, 16'hC35A);
    $display("word transfer done");
    slow <= 1;
    xfer(4, 8'h00);
    apb(1, dhlc_pkg::DHLC_OFS_CTRL, 8'h40);
    chk(abort_notify, 1);
    wait_done();
    chk(adv_n < 4, 1);
    apb(1, dhlc_pkg::DHLC_OFS_CTRL, 0);
    apb(1, dhlc_pkg::DHLC_OFS_IRQ, 0);
    xfer(4, 8'h00);
    host_attention <= 1;
    wait_done();
    chk(adv_n < 4, 1);
    chk(dma_irq, 1);
    host_attention <= 0;
    apb(1, dhlc_pkg::DHLC_OFS_IRQ, 2);
    chk(dma_irq, 0);
    word <= ~word;
    xfer(1, 8'h10);
    wait_done();
    chk(adv_n, 1);
    apb(0, dhlc_pkg::DHLC_OFS_INBUF, 0);
    chk(q, {16'h0, ~word});
    $display("abort paths done");
    host_function_inputs <= 3'b010;
    repeat (4) @(posedge pclk);
    chk(dma_irq, 1);
    apb(0, dhlc_pkg::DHLC_OFS_STATUS, 0);
    chk(q, st(1));
    host_function_inputs <= 3'b000;
    repeat (4) @(posedge pclk);
    chk(dma_irq, 1);
    apb(1, dhlc_pkg::DHLC_OFS_IRQ, 3);
    chk(dma_irq, 0);
    $display("function two interrupt done");
    give_verdict();
  end
endmodule // dhlc_top_tb
